//--- cfg_pkg.sv
/*
 * Constants shared by the switch configuration decoder, its register slave
 * and its selection helper.
 * Assumes a single 250 MHz clock domain and static board switches.
 */
// Summary of operation
// - Analog channel carries the switch-selected humidity parameter.
// - Switch selection uses fixed default full-scale span.
// - Any selection switch overrides software output settings.
// - MS/TP accepts addresses 0..127, master only.
// - RTU accepts addresses 1..247.
// - Address above maximum clamps to maximum.
// - Address below minimum clamps to minimum.
// - 4800 rate only in RTU mode.
// - All rate switches off gives protocol default.
// - Parity switch applies only in RTU mode.
// - Rate switches select 4800 up to 115200.
// - One switch picks RTU or MS/TP protocol.
// - Indicators show link transmit and receive activity.
// - Register number minus one is the protocol address.
package cfg_pkg;

  // Humidity parameter codes, in priority order.
  typedef enum logic [2:0] {
    PARAM_RH = 3'h0,
    PARAM_DEW = 3'h1,
    PARAM_DEW_FROST = 3'h2,
    PARAM_ABS_HUM = 3'h3,
    PARAM_MIX = 3'h4,
    PARAM_WET_BULB = 3'h5,
    PARAM_ENTHALPY = 3'h6
  } param_t;

  localparam int NUM_PARAMS = 7;

  // Bit rate codes; switch code zero means protocol default.
  typedef enum logic [2:0] {
    RATE_DEFAULT = 3'h0,
    RATE_4800 = 3'h1,
    RATE_9600 = 3'h2,
    RATE_19200 = 3'h3,
    RATE_38400 = 3'h4,
    RATE_57600 = 3'h5,
    RATE_76800 = 3'h6,
    RATE_115200 = 3'h7
  } rate_t;

  // Bit rates in bit/s, held at 17 bits.
  localparam logic [16:0] BPS_4800 = 17'h012C0;
  localparam logic [16:0] BPS_9600 = 17'h02580;
  localparam logic [16:0] BPS_19200 = 17'h04B00;
  localparam logic [16:0] BPS_38400 = 17'h09600;
  localparam logic [16:0] BPS_57600 = 17'h0E100;
  localparam logic [16:0] BPS_76800 = 17'h12C00;
  localparam logic [16:0] BPS_115200 = 17'h1C200;

  // Station address limits per protocol.
  localparam logic [7:0] RTU_ADDR_MIN = 8'h01;
  localparam logic [7:0] RTU_ADDR_MAX = 8'hF7;
  localparam logic [7:0] MSTP_ADDR_MIN = 8'h00;
  localparam logic [7:0] MSTP_ADDR_MAX = 8'h7F;

  // Default full-scale endpoints, signed, in whole units.
  localparam logic signed [15:0] SCALE_RH_LO = 16'sh0000;
  localparam logic signed [15:0] SCALE_RH_HI = 16'sh0064;
  localparam logic signed [15:0] SCALE_TEMP_LO = 16'shFFD8;
  localparam logic signed [15:0] SCALE_TEMP_HI = 16'sh0050;
  localparam logic signed [15:0] SCALE_ABS_LO = 16'sh0000;
  localparam logic signed [15:0] SCALE_ABS_HI = 16'sh012C;
  localparam logic signed [15:0] SCALE_MIX_LO = 16'sh0000;
  localparam logic signed [15:0] SCALE_MIX_HI = 16'sh0258;
  localparam logic signed [15:0] SCALE_ENTH_LO = 16'shFFD8;
  localparam logic signed [15:0] SCALE_ENTH_HI = 16'sh0640;

  // Scaled integer ceiling for measurement registers.
  localparam logic signed [15:0] INT_SAT_MAX = 16'sh7FFF;

  // Register byte offsets.
  localparam logic [7:0] OFF_SWITCHES = 8'h00;
  localparam logic [7:0] OFF_SW_OUTPUT = 8'h04;
  localparam logic [7:0] OFF_SW_SCALE = 8'h08;
  localparam logic [7:0] OFF_ACTIVE_OUT = 8'h0C;
  localparam logic [7:0] OFF_ACTIVE_SCALE = 8'h10;
  localparam logic [7:0] OFF_SERIAL = 8'h14;
  localparam logic [7:0] OFF_REG_NUM = 8'h18;
  localparam logic [7:0] OFF_PDU_ADDR = 8'h1C;

  // Reset values of software registers.
  localparam logic [2:0] SW_OUTPUT_RST = 3'h0;
  localparam logic [31:0] SW_SCALE_RST = 32'h00640000;
  localparam logic [15:0] REG_NUM_RST = 16'h0001;

  // Activity indicator stretch: 50 ms at 250 MHz.
  localparam int CLK_MHZ = 250;
  localparam int LED_HOLD_MS = 50;
  localparam int LED_HOLD_CYCLES = LED_HOLD_MS * 1000 * CLK_MHZ;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Converts a rate code to bit/s under the active protocol.
  function automatic logic [16:0] rate_bps(input rate_t code, input logic mstp);
    logic [16:0] bps;
    bps = BPS_19200;
    unique case (code)
      RATE_DEFAULT: bps = mstp ? BPS_38400 : BPS_19200;
      RATE_4800: bps = mstp ? BPS_9600 : BPS_4800;
      RATE_9600: bps = BPS_9600;
      RATE_19200: bps = BPS_19200;
      RATE_38400: bps = BPS_38400;
      RATE_57600: bps = BPS_57600;
      RATE_76800: bps = BPS_76800;
      RATE_115200: bps = BPS_115200;
    endcase
    return bps;
  endfunction : rate_bps

endpackage : cfg_pkg

//--- param_select.sv
/*
 * Picks the humidity parameter driven on the analog channel and its span.
 * Assumes one-hot selection switches, bit 0 relative humidity.
 */
`timescale 1ns/1ps
module param_select (
  input wire logic [6:0] sel_sw, // Selection switches, high is on.
  input wire logic [2:0] sw_param, // Parameter stored by software.
  input wire logic [31:0] sw_scale, // Span stored by software, hi:lo.
  output logic [2:0] out_param, // Parameter in effect.
  output logic [31:0] out_scale, // Span in effect, hi:lo.
  output logic switch_override // A selection switch is on.
);

  // Lowest-numbered switch on wins; with none on, software settings hold.
  always_comb begin
    out_param = sw_param;
    out_scale = sw_scale;
    switch_override = |sel_sw;
    for (int i = cfg_pkg::NUM_PARAMS - 1; i >= 0; i--) begin
      if (sel_sw[i]) begin
        out_param = 3'(i);
      end
    end
    if (switch_override) begin
      unique case (cfg_pkg::param_t'(out_param))
        cfg_pkg::PARAM_RH: out_scale = {cfg_pkg::SCALE_RH_HI, cfg_pkg::SCALE_RH_LO};
        cfg_pkg::PARAM_DEW, cfg_pkg::PARAM_DEW_FROST, cfg_pkg::PARAM_WET_BULB:
          out_scale = {cfg_pkg::SCALE_TEMP_HI, cfg_pkg::SCALE_TEMP_LO};
        cfg_pkg::PARAM_ABS_HUM: out_scale = {cfg_pkg::SCALE_ABS_HI, cfg_pkg::SCALE_ABS_LO};
        cfg_pkg::PARAM_MIX: out_scale = {cfg_pkg::SCALE_MIX_HI, cfg_pkg::SCALE_MIX_LO};
        cfg_pkg::PARAM_ENTHALPY: out_scale = {cfg_pkg::SCALE_ENTH_HI, cfg_pkg::SCALE_ENTH_LO};
        default: out_scale = sw_scale;
      endcase
    end
  end

endmodule : param_select

//--- activity_led.sv
/*
 * Stretches a one-cycle activity pulse into a visible indicator level.
 * Assumes pulses synchronous to aclk.
 */
`timescale 1ns/1ps
module activity_led #(
  parameter int HOLD = cfg_pkg::LED_HOLD_CYCLES // Cycles the light stays on.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic pulse, // One-cycle activity event.
  output logic led // Indicator level, high is lit.
);

  logic [23:0] count_reg;

  // Reloads on each event and counts down to dark.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 24'h000000;
    end else if (pulse) begin
      count_reg <= 24'(HOLD);
    end else if (count_reg != 24'h000000) begin
      count_reg <= count_reg - 24'h000001;
    end
  end

  assign led = (count_reg != 24'h000000);

endmodule : activity_led

//--- switch_config_decoder.sv
/*
 * Switch configuration decoder: turns board switches into output parameter,
 * span, station address, bit rate, parity and protocol, with an AXI4-Lite
 * slave for software settings and status.
 * Assumes switches static and synchronous to aclk, and a 250 MHz clock.
 */
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module switch_config_decoder #(
  parameter int LED_HOLD = cfg_pkg::LED_HOLD_CYCLES // Indicator stretch in cycles.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [6:0] param_sw, // Humidity parameter switches, bit 0 RH.
  input wire logic [7:0] addr_sw, // Address switches, bit 7 weight 128.
  input wire logic [2:0] rate_sw, // Bit rate switches.
  input wire logic parity_sw, // High selects even parity.
  input wire logic proto_sw, // High selects MS/TP, low RTU.
  input wire logic tx_event, // One-cycle pulse per sent frame.
  input wire logic rx_event, // One-cycle pulse per received frame.
  output logic [2:0] out_param, // Parameter on the humidity channel.
  output logic [31:0] out_scale, // Span hi:lo, signed whole units.
  output logic [7:0] station_addr, // Clamped station address.
  output logic [16:0] bit_rate, // Serial rate in bit/s.
  output logic parity_even, // Even parity in effect.
  output logic proto_mstp, // MS/TP in effect.
  output logic mstp_master, // Node acts as master.
  output logic tx_led, // Transmit indicator.
  output logic rx_led, // Receive indicator.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);

  logic [2:0] sw_output_reg;
  logic [31:0] sw_scale_reg;
  logic [15:0] reg_num_reg;
  logic [7:0] addr_next;
  logic [7:0] addr_reg;
  logic [16:0] rate_next;
  logic [16:0] rate_reg;
  logic parity_reg;
  logic proto_reg;
  logic [2:0] sel_param;
  logic [31:0] sel_scale;
  logic override;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic [31:0] rd_value;
  logic rd_hit;
  logic wr_hit;

  // Output parameter choice and span.
  param_select u_param_select (
    .sel_sw(param_sw),
    .sw_param(sw_output_reg),
    .sw_scale(sw_scale_reg),
    .out_param(sel_param),
    .out_scale(sel_scale),
    .switch_override(override)
  );

  // Address clamp per protocol; binary weights come straight from the switches.
  always_comb begin
    addr_next = addr_sw;
    if (proto_sw) begin
      if (addr_sw > cfg_pkg::MSTP_ADDR_MAX) begin
        addr_next = cfg_pkg::MSTP_ADDR_MAX;
      end else if (addr_sw < cfg_pkg::MSTP_ADDR_MIN) begin
        addr_next = cfg_pkg::MSTP_ADDR_MIN;
      end
    end else begin
      if (addr_sw > cfg_pkg::RTU_ADDR_MAX) begin
        addr_next = cfg_pkg::RTU_ADDR_MAX;
      end else if (addr_sw < cfg_pkg::RTU_ADDR_MIN) begin
        addr_next = cfg_pkg::RTU_ADDR_MIN;
      end
    end
  end

  // Rate from switches; the slowest code is raised to 9600 under MS/TP.
  always_comb begin
    rate_next = cfg_pkg::rate_bps(cfg_pkg::rate_t'(rate_sw), proto_sw);
  end

  // Serial settings registered so outputs come from flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= cfg_pkg::RTU_ADDR_MIN;
      rate_reg <= cfg_pkg::BPS_19200;
      parity_reg <= 1'b0;
      proto_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      rate_reg <= rate_next;
      parity_reg <= parity_sw & ~proto_sw;
      proto_reg <= proto_sw;
    end
  end

  // Analog selection registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_param <= cfg_pkg::SW_OUTPUT_RST;
      out_scale <= cfg_pkg::SW_SCALE_RST;
    end else begin
      out_param <= sel_param;
      out_scale <= sel_scale;
    end
  end

  assign station_addr = addr_reg;
  assign bit_rate = rate_reg;
  assign parity_even = parity_reg;
  assign proto_mstp = proto_reg;
  assign mstp_master = proto_reg;

  // Link activity indicators.
  activity_led #(.HOLD(LED_HOLD)) u_tx_led (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse(tx_event),
    .led(tx_led)
  );
  activity_led #(.HOLD(LED_HOLD)) u_rx_led (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse(rx_event),
    .led(rx_led)
  );

  // Write channel: address and data are caught in either order.
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  assign wr_hit = (awaddr_reg == cfg_pkg::OFF_SW_OUTPUT) ||
    (awaddr_reg == cfg_pkg::OFF_SW_SCALE) || (awaddr_reg == cfg_pkg::OFF_REG_NUM);

  // Software settings, written with byte strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_output_reg <= cfg_pkg::SW_OUTPUT_RST;
      sw_scale_reg <= cfg_pkg::SW_SCALE_RST;
      reg_num_reg <= cfg_pkg::REG_NUM_RST;
    end else if (do_write) begin
      if (awaddr_reg == cfg_pkg::OFF_SW_OUTPUT && wstrb_reg[0] && wdata_reg[2:0] <= 3'h6) begin
        sw_output_reg <= wdata_reg[2:0];
      end
      if (awaddr_reg == cfg_pkg::OFF_SW_SCALE) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            sw_scale_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
          end
        end
      end
      if (awaddr_reg == cfg_pkg::OFF_REG_NUM) begin
        for (int b = 0; b < 2; b++) begin
          if (wstrb_reg[b]) begin
            reg_num_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
          end
        end
      end
    end
  end

  // Write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? cfg_pkg::RESP_OKAY : cfg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read decode; the protocol address is the register number less one.
  always_comb begin
    rd_value = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      cfg_pkg::OFF_SWITCHES:
        rd_value = {12'h000, proto_sw, parity_sw, rate_sw, addr_sw, param_sw};
      cfg_pkg::OFF_SW_OUTPUT: rd_value = {29'h00000000, sw_output_reg};
      cfg_pkg::OFF_SW_SCALE: rd_value = sw_scale_reg;
      cfg_pkg::OFF_ACTIVE_OUT: rd_value = {27'h0000000, override, 1'b0, out_param};
      cfg_pkg::OFF_ACTIVE_SCALE: rd_value = out_scale;
      cfg_pkg::OFF_SERIAL:
        rd_value = {3'h0, proto_reg, parity_reg, 2'h0, rate_reg, addr_reg};
      cfg_pkg::OFF_REG_NUM: rd_value = {16'h0000, reg_num_reg};
      cfg_pkg::OFF_PDU_ADDR: rd_value = {16'h0000, reg_num_reg - 16'h0001};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~rvalid_reg;

  // Read response registered one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= cfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_hit ? cfg_pkg::RESP_OKAY : cfg_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : switch_config_decoder

//--- cfg_props.sv
/* Checker for the switch configuration decoder, watching its top ports.
   Assumes it is bound to the decoder and that one clock drives it all. */
`timescale 1ns/1ps
module cfg_props #(
  parameter int LED_HOLD = 8 // Indicator stretch.
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, low.
  input wire logic [6:0] param_sw, // Selection.
  input wire logic [7:0] addr_sw, // Address.
  input wire logic [2:0] rate_sw, // Rate code.
  input wire logic parity_sw, // Parity.
  input wire logic proto_sw, // Protocol.
  input wire logic tx_event, // Sent frame.
  input wire logic rx_event, // Got frame.
  input wire logic [2:0] out_param, // Parameter.
  input wire logic [31:0] out_scale, // Span.
  input wire logic [7:0] station_addr, // Address.
  input wire logic [16:0] bit_rate, // Rate.
  input wire logic parity_even, // Parity.
  input wire logic proto_mstp, // Protocol.
  input wire logic mstp_master, // Master.
  input wire logic tx_led, // Tx light.
  input wire logic rx_led, // Rx light.
  input wire logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic s_axi_rvalid // R valid.
);
  logic [7:0] addr_exp;
  logic [7:0] tx_age_reg;

  // Clamped address the decoder should produce from the present switches.
  always_comb begin
    if (proto_sw) begin
      addr_exp = (addr_sw > 8'h7F) ? 8'h7F : addr_sw;
    end else begin
      addr_exp = (addr_sw == 8'h00) ? 8'h01 : ((addr_sw > 8'hF7) ? 8'hF7 : addr_sw);
    end
  end

  // Cycles since the last transmit event, saturating so it never wraps.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_age_reg <= 8'hFF;
    end else if (tx_event) begin
      tx_age_reg <= 8'h00;
    end else if (tx_age_reg != 8'hFF) begin
      tx_age_reg <= tx_age_reg + 8'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ar_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rx_lit_s;
    rx_led [*2];
  endsequence

  chk_addr_clamp: assert property ($past(aresetn) |-> station_addr == $past(addr_exp))
    else $error("station address not clamped");
  chk_proto_pick: assert property ($past(aresetn) |-> proto_mstp == $past(proto_sw) && mstp_master == proto_mstp)
    else $error("protocol does not follow switch");
  chk_parity_gate: assert property ($past(aresetn) |-> parity_even == ($past(parity_sw) && !$past(proto_sw)))
    else $error("parity applied wrongly");
  chk_rate_default: assert property ($past(aresetn) && $past(rate_sw) == 3'h0 |-> bit_rate == ($past(proto_sw) ? cfg_pkg::BPS_38400 : cfg_pkg::BPS_19200))
    else $error("default rate wrong");
  chk_rate_floor: assert property ($past(aresetn) && $past(proto_sw) |-> bit_rate >= cfg_pkg::BPS_9600)
    else $error("slow rate under second protocol");
  chk_rate_top: assert property ($past(aresetn) && $past(rate_sw) == 3'h7 |-> bit_rate == cfg_pkg::BPS_115200)
    else $error("top rate wrong");
  chk_param_first: assert property ($past(aresetn) && $past(param_sw[0]) |-> out_param == 3'h0 && out_scale == 32'h00640000)
    else $error("first parameter not chosen");
  chk_param_last: assert property ($past(aresetn) && $past(param_sw) == 7'h40 |-> out_param == 3'h6 && out_scale == 32'h0640FFD8)
    else $error("last parameter span wrong");
  chk_tx_lit: assert property (tx_age_reg < LED_HOLD |-> tx_led)
    else $error("transmit light dark too soon");
  chk_tx_dark: assert property (tx_age_reg >= LED_HOLD |-> !tx_led)
    else $error("transmit light lit too long");
  chk_rx_lit: assert property (rx_event |=> rx_lit_s)
    else $error("receive light not lit");
  chk_read_answer: assert property (ar_taken_s |=> s_axi_rvalid)
    else $error("read not answered");
endmodule : cfg_props

//--- link_partner.sv
/* Behavioural host on the serial link: a request frame, then a reply.
   Assumes requests are one-cycle go pulses from the bench. */
`timescale 1ns/1ps
module link_partner (
  input wire logic aclk, // Clock.
  input wire logic go, // Start exchange.
  input wire logic [3:0] gap, // Reply delay.
  output logic rx_event, // Host frame.
  output logic tx_event // Reply frame.
);
  // The reply leaves after a prompt or slow gap, as a real host sees it.
  initial begin
    rx_event = 1'b0;
    tx_event = 1'b0;
    forever begin
      @(posedge aclk);
      if (go === 1'b1) begin
        rx_event <= 1'b1;
        @(posedge aclk);
        rx_event <= 1'b0;
        repeat (gap) @(posedge aclk);
        tx_event <= 1'b1;
        @(posedge aclk);
        tx_event <= 1'b0;
      end
    end
  end
endmodule : link_partner

//--- switch_config_decoder_tb.sv
/* Self-checking bench for the switch configuration decoder.
   Assumes the checker and the link partner are compiled alongside. */
`timescale 1ns/1ps
module switch_config_decoder_tb;
  localparam int LED_HOLD = 8;
  logic aclk = 1'b0, aresetn = 1'b0, parity_sw = 1'b0, proto_sw = 1'b0, go = 1'b0;
  logic [6:0] param_sw = 7'h00;
  logic [7:0] addr_sw = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] rate_sw = 3'h0, out_param;
  logic [3:0] gap = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, out_scale, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_event, rx_event;
  logic [7:0] station_addr;
  logic [16:0] bit_rate;
  logic parity_even, proto_mstp, mstp_master, tx_led, rx_led;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  integer seed = 32'hE930;
  int fails = 0;
  int n_compared = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [7:0] tab [8] = '{8'h00, 8'h01, 8'h29, 8'h7F, 8'h80, 8'hF7, 8'hF8, 8'hFF};

  switch_config_decoder #(.LED_HOLD(LED_HOLD)) u_switch_config_decoder (.aclk, .aresetn,
    .param_sw, .addr_sw, .rate_sw, .parity_sw, .proto_sw, .tx_event, .rx_event, .out_param,
    .out_scale, .station_addr, .bit_rate, .parity_even, .proto_mstp, .mstp_master, .tx_led,
    .rx_led, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  link_partner u_link_partner (.aclk, .go, .gap, .rx_event, .tx_event);

  // Clock of 4 ns period.
  always #2 aclk = ~aclk;

  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  // Takes the oldest note whenever a response is handed over.
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) cmp({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    rq.push_back({cfg_pkg::RESP_OKAY, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic setsw(input logic [6:0] ps, input logic [7:0] a, input logic [2:0] c,
                       input logic p, input logic m);
    @(posedge aclk);
    param_sw <= ps;
    addr_sw <= a;
    rate_sw <= c;
    parity_sw <= p;
    proto_sw <= m;
    repeat (2) @(posedge aclk);
  endtask : setsw

  function automatic logic [7:0] ea(input logic [7:0] a, input logic m);
    if (m) return (a > 8'h7F) ? 8'h7F : a;
    return (a == 8'h00) ? 8'h01 : ((a > 8'hF7) ? 8'hF7 : a);
  endfunction : ea

  function automatic logic [16:0] eb(input logic [2:0] c, input logic m);
    case (c)
      3'h0: return m ? cfg_pkg::BPS_38400 : cfg_pkg::BPS_19200;
      3'h1: return m ? cfg_pkg::BPS_9600 : cfg_pkg::BPS_4800;
      3'h2: return cfg_pkg::BPS_9600;
      3'h3: return cfg_pkg::BPS_19200;
      3'h4: return cfg_pkg::BPS_38400;
      3'h5: return cfg_pkg::BPS_57600;
      3'h6: return cfg_pkg::BPS_76800;
      default: return cfg_pkg::BPS_115200;
    endcase
  endfunction : eb

  function automatic logic [31:0] es(input logic [2:0] k);
    case (k)
      3'h0: return 32'h00640000;
      3'h3: return 32'h012C0000;
      3'h4: return 32'h02580000;
      3'h6: return 32'h0640FFD8;
      default: return 32'h0050FFD8;
    endcase
  endfunction : es

  function automatic logic [2:0] lo(input logic [6:0] ps);
    logic [2:0] r;
    r = 3'h0;
    for (int j = 6; j >= 0; j--) if (ps[j]) r = j[2:0];
    return r;
  endfunction : lo

  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // Main sequence of tests.
  initial begin
    logic [7:0] a;
    logic [6:0] ps;
    logic m, p;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cfg_pkg::OFF_SW_SCALE, cfg_pkg::SW_SCALE_RST);
    rd(cfg_pkg::OFF_REG_NUM, 32'h1);
    wr(8'h40, 32'h1, cfg_pkg::RESP_SLVERR);
    wr(cfg_pkg::OFF_SERIAL, 32'h1, cfg_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      a = (i < 16) ? tab[i % 8] : 8'($random(seed));
      m = i[3];
      p = 1'($random(seed));
      setsw(7'h00, a, i[2:0], p, m);
      rd(cfg_pkg::OFF_SERIAL, {3'h0, m, p & ~m, 2'h0, eb(i[2:0], m), ea(a, m)});
      rd(cfg_pkg::OFF_SWITCHES, {12'h0, m, p, i[2:0], a, 7'h00});
    end
    $display("test serial done");
    for (int k = 0; k < 7; k++) begin
      setsw(7'h01 << k, 8'h29, 3'h0, 1'b0, 1'b0);
      rd(cfg_pkg::OFF_ACTIVE_OUT, {27'h1, 1'b0, k[2:0]});
      rd(cfg_pkg::OFF_ACTIVE_SCALE, es(k[2:0]));
    end
    for (int k = 0; k < 4; k++) begin
      ps = 7'($random(seed)) | 7'h40;
      setsw(ps, 8'h29, 3'h0, 1'b0, 1'b0);
      rd(cfg_pkg::OFF_ACTIVE_OUT, {27'h1, 1'b0, lo(ps)});
    end
    setsw(7'h08, 8'h29, 3'h0, 1'b0, 1'b0);
    wr(cfg_pkg::OFF_SW_OUTPUT, 32'h5, cfg_pkg::RESP_OKAY);
    wr(cfg_pkg::OFF_SW_SCALE, 32'h1234ABCD, cfg_pkg::RESP_OKAY);
    rd(cfg_pkg::OFF_ACTIVE_OUT, 32'h13);
    rd(cfg_pkg::OFF_ACTIVE_SCALE, 32'h012C0000);
    setsw(7'h00, 8'h29, 3'h0, 1'b0, 1'b0);
    rd(cfg_pkg::OFF_ACTIVE_OUT, 32'h5);
    rd(cfg_pkg::OFF_ACTIVE_SCALE, 32'h1234ABCD);
    wr(cfg_pkg::OFF_SW_OUTPUT, 32'h7, cfg_pkg::RESP_OKAY);
    rd(cfg_pkg::OFF_ACTIVE_OUT, 32'h5);
    $display("test parameter done");
    wr(cfg_pkg::OFF_REG_NUM, 32'h101, cfg_pkg::RESP_OKAY);
    rd(cfg_pkg::OFF_PDU_ADDR, 32'h100);
    wr(cfg_pkg::OFF_REG_NUM, 32'h0, cfg_pkg::RESP_OKAY);
    rd(cfg_pkg::OFF_PDU_ADDR, 32'hFFFF);
    $display("test numbering done");
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      go <= 1'b1;
      gap <= (k == 0) ? 4'h0 : 4'($random(seed));
      @(posedge aclk);
      go <= 1'b0;
      repeat (3 * LED_HOLD + 16) @(posedge aclk);
    end
    $display("test activity done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cfg_pkg::OFF_SW_OUTPUT, 32'h0);
    $display("test second reset done");
    end_of_test;
  end

  // Watchdog that ends a hung run.
  initial begin
    #50us;
    fails++;
    end_of_test;
  end
endmodule : switch_config_decoder_tb

bind switch_config_decoder cfg_props #(.LED_HOLD(LED_HOLD)) u_cfg_props (.aclk, .aresetn,
  .param_sw, .addr_sw, .rate_sw, .parity_sw, .proto_sw, .tx_event, .rx_event, .out_param,
  .out_scale, .station_addr, .bit_rate, .parity_even, .proto_mstp, .mstp_master, .tx_led,
  .rx_led, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
